// ---- src/bsmc_pkg.sv ----
`default_nettype none
package bsmc_pkg;
    // ==================================================================
    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int OV_DELAY_NS = 5000;
    localparam int OV_CYC = (OV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LS_MIN_NS = 250;
    localparam int LS_MIN_CYC = (LS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SS_OSC_HZ = 500_000;
    localparam int SS_TICK_DIV = CLK_HZ / SS_OSC_HZ;
    localparam int SS_FULL_UV = 500_000;
    localparam int SS_STEP_UV = 1200;
    localparam int SS_STEPS = (SS_FULL_UV + SS_STEP_UV - 1) / SS_STEP_UV;
    localparam int STARTUP_5V_US = 2000;
    localparam int STARTUP_3V3_US = 1000;
    localparam int STARTUP_5V_CYC = STARTUP_5V_US * CLK_MHZ;
    localparam int STARTUP_3V3_CYC = STARTUP_3V3_US * CLK_MHZ;
    localparam int US_CAP_PF = 350;
    localparam int ZC_ENTRY = 8;
    // ==================================================================
    // widths
    localparam int REF_W = 9;
    localparam int CNT_W = 24;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    // ==================================================================
    // synchronised comparator and pin inputs, bit positions
    localparam int IN_EN = 0;
    localparam int IN_BIAS_OK = 1;
    localparam int IN_BIAS_LOW = 2;
    localparam int IN_SEL_AT_BIAS = 3;
    localparam int IN_SEL_OPEN = 4;
    localparam int IN_FB_LOW = 5;
    localparam int IN_FB_SMART = 6;
    localparam int IN_FB_OVER = 7;
    localparam int IN_FB_UNDER = 8;
    localparam int IN_FB_GOOD = 9;
    localparam int IN_ZC = 10;
    localparam int IN_VALLEY = 11;
    localparam int IN_SW_NODE = 12;
    localparam int IN_ON_DONE = 13;
    localparam int NIN = 14;
    // ==================================================================
    // register map
    localparam logic [AXI_AW-1:0] REG_LIMIT = 8'h00;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [AXI_AW-1:0] REG_LEVEL = 8'h08;
    localparam logic [CNT_W-1:0] LIMIT_OHM_RST = 24'h01be6e;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_MODE_LSB = 3;
    localparam int STAT_PSAVE_BIT = 5;
    localparam int STAT_SMART_BIT = 6;
    localparam int STAT_SS_BIT = 7;
    localparam int STAT_DLY_BIT = 8;
    localparam int STAT_GOOD_BIT = 9;
    localparam int LEVEL_ZC_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ==================================================================
    // types
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_HS = 3'h1,
        ST_LS = 3'h3,
        ST_WAIT = 3'h2,
        ST_FAULT = 3'h6
    } bsmc_state_e;
    typedef enum logic [1:0] {
        MODE_CCM = 2'h0,
        MODE_ULTRA = 2'h1,
        MODE_PSAVE = 2'h2
    } bsmc_mode_e;
endpackage
`default_nettype wire

// ---- src/bsmc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsmc_top #(
    parameter int STARTUP_5V = bsmc_pkg::STARTUP_5V_CYC,
    parameter int STARTUP_3V3 = bsmc_pkg::STARTUP_3V3_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic enable_pin,
    input wire logic bias_ok,
    input wire logic bias_is_3v3,
    input wire logic light_load_select_pin_at_bias,
    input wire logic light_load_select_pin_open,
    input wire logic feedback_input_below_ref,
    input wire logic feedback_input_above_550,
    input wire logic feedback_input_above_600,
    input wire logic feedback_input_below_90pct,
    input wire logic feedback_input_above_92pct,
    input wire logic zero_cross,
    input wire logic valley_limit_sense_neg,
    input wire logic switch_node_high,
    input wire logic on_time_done,
    output logic high_side_gate,
    output logic high_side_fast_drive,
    output logic low_side_gate,
    output logic discharge_en,
    output logic output_ok_flag_o,
    output logic output_ok_flag_oe,
    output logic [bsmc_pkg::REF_W-1:0] ref_code,
    output logic ref_fixed,
    input wire logic [bsmc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [bsmc_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [bsmc_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [bsmc_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import bsmc_pkg::*;

    if (STARTUP_5V < 1 || STARTUP_5V >= (1 << CNT_W) || STARTUP_3V3 < 1
            || STARTUP_3V3 >= (1 << CNT_W)) begin : g_chk
        $error("start-up delay counts out of range");
    end

    // ==================================================================
    // state
    typedef struct packed {
        logic [NIN-1:0] sy1;
        logic [NIN-1:0] sy2;
        bsmc_state_e st;
        bsmc_mode_e md;
        logic [5:0] ovc;
        logic [4:0] tick;
        logic [REF_W-1:0] ss_cnt;
        logic ss_done;
        logic [CNT_W-1:0] dly;
        logic dly_done;
        logic [1:0] ls_cnt;
        logic [3:0] zc_cnt;
        logic zc_seen;
        logic psave;
        logic smart;
        logic [CNT_W-1:0] us_cnt;
        logic [CNT_W-1:0] us_lim;
        logic [CNT_W-1:0] lim_ohm;
        logic good;
        logic pull;
        logic hs;
        logic fast;
        logic ls;
        logic disch;
        logic [REF_W-1:0] ref_c;
        logic aw_held;
        logic [AXI_AW-1:0] aw_addr;
        logic w_held;
        logic [AXI_DW-1:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [AXI_DW-1:0] rdata;
        logic [1:0] rresp;
    } bsmc_regs_s;

    bsmc_regs_s r;
    bsmc_regs_s n;

    // ==================================================================
    // helpers
    function automatic bsmc_mode_e decode_mode(input logic at_bias, input logic open_pin);
        if (at_bias) begin
            return MODE_CCM;
        end else if (open_pin) begin
            return MODE_PSAVE;
        end
        return MODE_ULTRA;
    endfunction

    function automatic logic [CNT_W-1:0] ohm_to_cycles(input logic [CNT_W-1:0] ohm);
        logic [47:0] p;
        p = 48'(ohm) * 48'(US_CAP_PF * CLK_MHZ);
        return CNT_W'(p / 48'd1000000);
    endfunction

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction

    // ==================================================================
    // next state
    always_comb begin
        logic [NIN-1:0] s;
        logic run;
        logic start_hs;
        logic to_ls;
        logic [CNT_W-1:0] dly_lim;
        logic [AXI_DW-1:0] nd;
        s = r.sy2;
        run = s[IN_EN] && s[IN_BIAS_OK];
        start_hs = 1'b0;
        to_ls = 1'b0;
        dly_lim = s[IN_BIAS_LOW] ? CNT_W'(STARTUP_3V3) : CNT_W'(STARTUP_5V);
        nd = '0;
        n = r;
        n.sy1 = {on_time_done, switch_node_high, valley_limit_sense_neg, zero_cross,
                 feedback_input_above_92pct, feedback_input_below_90pct,
                 feedback_input_above_600, feedback_input_above_550,
                 feedback_input_below_ref, light_load_select_pin_open,
                 light_load_select_pin_at_bias, bias_is_3v3, bias_ok, enable_pin};
        n.sy2 = r.sy1;
        n.tick = (r.tick == 5'(SS_TICK_DIV - 1)) ? 5'h0 : r.tick + 5'h1;
        if (!run) begin
            // bias loss or enable low clears fault and soft-start
            n.st = ST_OFF;
            n.md = decode_mode(s[IN_SEL_AT_BIAS], s[IN_SEL_OPEN]);
            n.ovc = '0;
            n.ss_cnt = '0;
            n.ss_done = 1'b0;
            n.dly = '0;
            n.dly_done = 1'b0;
            n.zc_cnt = '0;
            n.psave = 1'b0;
            n.smart = 1'b0;
            n.us_cnt = '0;
            n.good = 1'b0;
        end else begin
            // over-voltage filter: must hold for the full delay
            n.ovc = s[IN_FB_OVER] ? ((r.ovc == 6'(OV_CYC - 1)) ? r.ovc : r.ovc + 6'h1) : 6'h0;
            // ramp reference one step per oscillator tick
            if (!r.ss_done && r.tick == 5'h0) begin
                n.ss_cnt = r.ss_cnt + 1'b1;
                n.ss_done = (r.ss_cnt == REF_W'(SS_STEPS - 1));
            end
            n.dly = sat_inc(r.dly);
            n.dly_done = r.dly_done || (r.dly >= dly_lim - 1'b1);
            n.us_cnt = sat_inc(r.us_cnt);
            n.ls_cnt = (r.ls_cnt != 2'h0) ? r.ls_cnt - 2'h1 : 2'h0;
            case (r.st)
                ST_OFF: begin
                    n.st = ST_WAIT;
                end
                ST_WAIT: begin
                    if (r.md != MODE_CCM && s[IN_FB_SMART]) begin
                        n.smart = 1'b1;
                        n.psave = 1'b0;
                        to_ls = 1'b1;
                    end else if (s[IN_FB_LOW]) begin
                        start_hs = 1'b1;
                    end else if (r.md == MODE_ULTRA && r.us_cnt >= r.us_lim) begin
                        to_ls = 1'b1;
                    end
                end
                ST_HS: begin
                    if (s[IN_ON_DONE]) begin
                        to_ls = 1'b1;
                        n.us_cnt = '0;
                        n.zc_seen = 1'b0;
                    end
                end
                ST_LS: begin
                    if (s[IN_ZC]) begin
                        n.zc_seen = 1'b1;
                    end
                    if (r.md != MODE_CCM && s[IN_FB_SMART]) begin
                        n.smart = 1'b1;
                        n.psave = 1'b0;
                    end
                    if (s[IN_VALLEY]) begin
                        n.st = ST_LS;
                    end else if (r.ls_cnt != 2'h0) begin
                        n.st = ST_LS;
                    end else if (s[IN_FB_LOW]) begin
                        start_hs = 1'b1;
                    end else if (s[IN_ZC] && !r.smart && !s[IN_FB_SMART]
                            && (r.psave || r.md == MODE_ULTRA || !r.ss_done)) begin
                        n.st = ST_WAIT;
                    end
                end
                ST_FAULT: begin
                    n.st = ST_FAULT;
                end
                default: begin
                    n.st = ST_OFF;
                end
            endcase
            if (start_hs) begin
                n.st = ST_HS;
                n.smart = 1'b0;
                if (r.md == MODE_PSAVE) begin
                    // a cycle ends here: count or drop the zero-crossing run
                    if (r.zc_seen) begin
                        n.zc_cnt = (r.zc_cnt == 4'(ZC_ENTRY - 1)) ? r.zc_cnt : r.zc_cnt + 4'h1;
                        n.psave = r.psave || (r.zc_cnt == 4'(ZC_ENTRY - 1));
                    end else begin
                        n.zc_cnt = 4'h0;
                        n.psave = 1'b0;
                    end
                end
            end
            if (to_ls) begin
                n.st = ST_LS;
                n.ls_cnt = 2'(LS_MIN_CYC - 1);
            end
            if (r.st == ST_FAULT || (s[IN_FB_OVER] && r.ovc == 6'(OV_CYC - 1))) begin
                n.st = ST_FAULT;
            end
            // hysteresis between -10% and -8%
            if (s[IN_FB_UNDER] || s[IN_FB_OVER] || n.st == ST_FAULT) begin
                n.good = 1'b0;
            end else if (s[IN_FB_GOOD] && r.ss_done && r.dly_done) begin
                n.good = 1'b1;
            end
        end
        n.hs = (n.st == ST_HS);
        // slow edge first; fast only after the node has risen
        n.fast = (n.st == ST_HS) && (r.st == ST_HS) && s[IN_SW_NODE];
        n.ls = (n.st == ST_LS) || (n.st == ST_FAULT);
        n.disch = !s[IN_EN] && s[IN_BIAS_OK];
        n.pull = !n.good; // own flop so the pin is glitch free
        n.ref_c = r.ss_done ? REF_W'(SS_STEPS) : r.ss_cnt;
        // ==============================================================
        // register bus, write side
        if (s_axi_awvalid && r.awready) begin
            n.aw_held = 1'b1;
            n.aw_addr = s_axi_awaddr;
            n.awready = 1'b0;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_held = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
            n.wready = 1'b0;
        end
        if (r.aw_held && r.w_held && !r.bvalid) begin
            n.bvalid = 1'b1;
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            if (r.aw_addr == REG_LIMIT) begin
                nd = AXI_DW'(r.lim_ohm);
                for (int i = 0; i < 4; i++) begin
                    if (r.wstrb[i]) begin
                        nd[i*8 +: 8] = r.wdata[i*8 +: 8];
                    end
                end
                n.lim_ohm = nd[CNT_W-1:0];
                n.us_lim = ohm_to_cycles(nd[CNT_W-1:0]);
                n.bresp = RESP_OKAY;
            end else if (r.aw_addr == REG_STATUS || r.aw_addr == REG_LEVEL) begin
                n.bresp = RESP_SLVERR;
            end else begin
                n.bresp = RESP_DECERR;
            end
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end
        // ==============================================================
        // register bus, read side
        if (s_axi_arvalid && r.arready) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = '0;
            case (s_axi_araddr)
                REG_LIMIT: begin
                    n.rdata = AXI_DW'(r.lim_ohm);
                end
                REG_STATUS: begin
                    n.rdata[STAT_STATE_LSB +: 3] = r.st;
                    n.rdata[STAT_MODE_LSB +: 2] = r.md;
                    n.rdata[STAT_PSAVE_BIT] = r.psave;
                    n.rdata[STAT_SMART_BIT] = r.smart;
                    n.rdata[STAT_SS_BIT] = r.ss_done;
                    n.rdata[STAT_DLY_BIT] = r.dly_done;
                    n.rdata[STAT_GOOD_BIT] = r.good;
                end
                REG_LEVEL: begin
                    n.rdata[REF_W-1:0] = r.ref_c;
                    n.rdata[LEVEL_ZC_LSB +: 4] = r.zc_cnt;
                end
                default: begin
                    n.rresp = RESP_DECERR;
                end
            endcase
        end
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            r <= '0;
            r.st <= ST_OFF;
            r.md <= MODE_CCM;
            r.lim_ohm <= LIMIT_OHM_RST;
            r.us_lim <= ohm_to_cycles(LIMIT_OHM_RST);
            r.pull <= 1'b1;
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.arready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ==================================================================
    // outputs
    assign high_side_gate = r.hs;
    assign high_side_fast_drive = r.fast;
    assign low_side_gate = r.ls;
    assign discharge_en = r.disch;
    assign output_ok_flag_o = 1'b0;
    assign output_ok_flag_oe = r.pull;
    assign ref_code = r.ref_c;
    assign ref_fixed = r.ss_done;
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;

    // ==================================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    logic run_s;
    assign run_s = r.sy2[IN_EN] && r.sy2[IN_BIAS_OK];

    gates_apart_a: assert property (!(high_side_gate && low_side_gate))
        else $error("both gates on");
    ccm_hold_a: assert property ((r.st == ST_LS && r.md == MODE_CCM && r.ss_done && run_s)
        |=> r.st != ST_WAIT) else $error("continuous mode released low gate");
    ls_min_a: assert property ((r.st == ST_LS && r.ls_cnt != 2'h0 && run_s)
        |=> low_side_gate && !high_side_gate) else $error("low gate minimum cut short");
    valley_hold_a: assert property ((r.st == ST_LS && r.sy2[IN_VALLEY] && run_s)
        |=> low_side_gate && !high_side_gate) else $error("valley limit ignored");
    ov_filter_a: assert property ($rose(r.st == ST_FAULT)
        |-> $past(r.ovc) == 6'(OV_CYC - 1)) else $error("over-voltage acted early");
    fault_latch_a: assert property ((r.st == ST_FAULT && run_s)
        |=> r.st == ST_FAULT ##0 low_side_gate ##0 output_ok_flag_oe)
        else $error("fault latch dropped");
    ok_enable_a: assert property ((!r.sy2[IN_EN] && r.sy2[IN_BIAS_OK])
        |=> output_ok_flag_oe && discharge_en) else $error("disabled output not pulled");
    ok_release_a: assert property ($fell(output_ok_flag_oe)
        |-> ref_fixed && r.dly_done) else $error("output ok released early");
    psave_entry_a: assert property ($rose(r.psave)
        |-> r.md == MODE_PSAVE && $past(r.zc_cnt) == 4'(ZC_ENTRY - 1))
        else $error("power-save entered early");
    smart_a: assert property ((r.st == ST_WAIT && r.md != MODE_CCM && r.sy2[IN_FB_SMART]
        && run_s && r.ovc == 6'h0) |=> low_side_gate && !r.psave) else $error("smart pull missed");
    ss_step_a: assert property ((run_s && !ref_fixed && r.tick == 5'h0)
        |=> ##1 (ref_code == $past(ref_code) + 1'b1 || !run_s)) else $error("ramp stalled");

    psave_c: cover property ($rose(r.psave));
    fault_c: cover property ($rose(r.st == ST_FAULT));
    ultra_c: cover property (r.st == ST_WAIT && r.md == MODE_ULTRA ##1 r.st == ST_LS);
    good_c: cover property ($fell(output_ok_flag_oe));
endmodule
`default_nettype wire

// ---- test/bsmc_power_stage.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// power switch pair and filter, behavioural
module bsmc_power_stage #(
    parameter int ON_CYC = 4
) (
    input wire logic mclk,
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    input wire logic light_load,
    output logic switch_node_high,
    output logic zero_cross,
    output logic on_time_done,
    output logic feedback_low
);
    logic [7:0] hs_cnt = 8'h0;
    logic [7:0] ls_cnt = 8'h0;
    always_ff @(posedge mclk) begin
        hs_cnt <= high_side_gate ? hs_cnt + 8'h1 : 8'h0;
        ls_cnt <= low_side_gate ? ls_cnt + 8'h1 : 8'h0;
        // node lags the gate: diode recovery first
        switch_node_high <= high_side_gate;
        on_time_done <= high_side_gate && (hs_cnt >= 8'(ON_CYC));
        // idle stage carries no current; light load drains it within 6 cycles
        zero_cross <= (!high_side_gate && !low_side_gate) || (light_load && ls_cnt >= 8'h6);
        // output sags to threshold once the inductor has run dry
        feedback_low <= (zero_cross && low_side_gate) || (!high_side_gate && !low_side_gate);
    end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_top;
    import bsmc_pkg::*;
    logic mclk = 0, nrst = 0, en = 0, bio = 0, fb_lo = 0, fb_600 = 0, fb_90 = 0;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic ll = 0, bok = 1, sat = 1, sop = 0, fb_550 = 0, follow = 0;
    logic fd, ok_o, fbm;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, seed = 32'hdfd2;
    logic hs, ls, dis, ok_oe, rf, awr, wr, bv, arr, rv, sn, zc, otd;
    logic [8:0] rc;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [65:0] q[$];
    logic [65:0] e;
    int errors = 0, checked = 0, cyc = 0, fast_seen = 0;
    always #50 mclk = ~mclk;
    // ==================================================================
    // far side and device
    bsmc_power_stage bsmc_power_stage_inst(.mclk(mclk), .high_side_gate(hs), .low_side_gate(ls),
        .light_load(ll), .switch_node_high(sn), .zero_cross(zc), .on_time_done(otd),
        .feedback_low(fbm));
    bsmc_top #(.STARTUP_5V(200), .STARTUP_3V3(100)) bsmc_top_inst(.mclk(mclk), .nrst(nrst),
        .enable_pin(en), .bias_ok(bok), .bias_is_3v3(bio), .light_load_select_pin_at_bias(sat),
        .light_load_select_pin_open(sop), .feedback_input_below_ref(follow ? fbm : fb_lo),
        .feedback_input_above_550(fb_550 || fb_600), .feedback_input_above_600(fb_600),
        .feedback_input_below_90pct(fb_90), .feedback_input_above_92pct(!fb_90),
        .zero_cross(zc), .valley_limit_sense_neg(1'b0), .switch_node_high(sn),
        .on_time_done(otd), .high_side_gate(hs), .high_side_fast_drive(fd), .low_side_gate(ls),
        .discharge_en(dis), .output_ok_flag_o(ok_o), .output_ok_flag_oe(ok_oe), .ref_code(rc),
        .ref_fixed(rf), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr));
    // ==================================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        q.push_back({32'h0, 32'h0, r});
        @(posedge mclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge mclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                       input logic [1:0] r);
        q.push_back({m, d, r});
        @(posedge mclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge mclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rr <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==================================================================
    // response watcher: oldest note against each answer, masked data
    always @(posedge mclk) begin
        if ((bv && br) || (rv && rr)) begin
            e = q.pop_front();
            `CHK((bv && br) ? {32'h0, bresp} : {rdata & e[65:34], rresp}, e[33:0])
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (fd) fast_seen++;
        if (fd) `CHK(hs, 1'b1)
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end
    // ==================================================================
    // main sequence
    initial begin
        bio <= seed[1];
        tick(5);
        nrst <= 1'b1;
        axr(REG_LIMIT, 32'hffffffff, {8'h0, LIMIT_OHM_RST}, RESP_OKAY);
        seed = xs(seed);
        axw(REG_LIMIT, seed, RESP_OKAY);
        axr(REG_LIMIT, 32'hffffffff, {8'h0, seed[23:0]}, RESP_OKAY);
        axw(REG_STATUS, seed, RESP_SLVERR);
        axr(8'hfc, 32'hffffffff, 32'h0, RESP_DECERR);
        axr(REG_STATUS, 32'h18, {27'h0, MODE_CCM, 3'h0}, RESP_OKAY);
        en <= 1'b1; // enable driven firmly
        repeat (9000) begin
            @(posedge mclk);
            seed = xs(seed);
            fb_lo <= seed[0];
        end
        `CHK(rf, 1'b1)
        `CHK(rc, 9'(SS_STEPS))
        `CHK(ok_oe, 1'b0)
        fb_lo <= 1'b0;
        fb_90 <= 1'b1;
        tick(6);
        `CHK(ok_oe, 1'b1)
        fb_90 <= 1'b0;
        tick(6);
        `CHK(ok_oe, 1'b0)
        // short excursion must not latch
        fb_600 <= 1'b1;
        tick(40);
        fb_600 <= 1'b0;
        tick(10);
        `CHK(ok_oe, 1'b0)
        fb_600 <= 1'b1;
        tick(60);
        `CHK(hs, 1'b0)
        `CHK(ls, 1'b1)
        fb_600 <= 1'b0;
        tick(10);
        `CHK(ls, 1'b1)
        `CHK(ok_oe, 1'b1)
        axr(REG_STATUS, 32'h7, {29'h0, ST_FAULT}, RESP_OKAY);
        en <= 1'b0;
        tick(6);
        `CHK(ls, 1'b0)
        `CHK(dis, 1'b1)
        `CHK(ok_oe, 1'b1)
        // light load, floating select pin: power-save entry, then smart pull
        sat <= 1'b0;
        sop <= 1'b1;
        ll <= 1'b1;
        follow <= 1'b1;
        tick(4);
        axr(REG_STATUS, 32'h18, {27'h0, MODE_PSAVE, 3'h0}, RESP_OKAY);
        en <= 1'b1;
        tick(600);
        axr(REG_STATUS, 32'h38, {26'h0, 1'b1, MODE_PSAVE, 3'h0}, RESP_OKAY);
        follow <= 1'b0;
        fb_550 <= 1'b1;
        tick(20);
        `CHK(ls, 1'b1)
        axr(REG_STATUS, 32'h60, {25'h0, 2'b10, 5'h0}, RESP_OKAY);
        fb_550 <= 1'b0;
        en <= 1'b0;
        sop <= 1'b0;
        tick(4);
        axr(REG_STATUS, 32'h18, {27'h0, MODE_ULTRA, 3'h0}, RESP_OKAY);
        bok <= 1'b0;
        tick(5);
        `CHK(dis, 1'b0)
        `CHK(fast_seen != 0, 1'b1)
        `CHK(ok_o, 1'b0)
        end_of_test();
    end
endmodule
`default_nettype wire
